// *** pam_port_a_mux.sv ***
// Function multiplexer for the seven shared port A pins.
// Assumes the PWM generator, fault logic and serial engine sit on the
// same clock and present their signals as plain levels.
`timescale 1ns/1ns
module pam_port_a_mux
  import pam_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1  // 1: full part, 0: reduced part.
) (
  input  wire logic                  clk_sys_in,      // System clock.
  input  wire logic                  rst_in,          // Chip reset.
  input  wire logic                  sel_load_in,     // Load a pin function.
  input  wire logic [PAM_SEL_W-1:0]  sel_pin_in,      // Pin to load.
  input  pam_func_t                  sel_func_in,     // Function to load.
  input  wire logic [PAM_NPIN-1:0]   gpio_dir_in,     // 1: GPIO output.
  input  wire logic [PAM_NPIN-1:0]   gpio_data_in,    // GPIO output level.
  input  wire logic [PAM_NPWM-1:0]   pwm_ch_in,       // Generator channels.
  input  pam_fault_map_t             fault_map_in,    // Fault to channel map.
  input  wire logic                  spi_master_in,   // 1: port is master.
  input  wire logic                  spi_miso_drv_in, // Engine slave data.
  input  wire logic                  spi_mosi_drv_in, // Engine master data.
  input  wire logic                  spi_sclk_drv_in, // Engine master clock.
  input  wire logic [PAM_NPIN-1:0]   pin_in,          // Pin levels.
  output pam_pins_t                  pins_out,        // Pin drive and enable.
  output logic [PAM_SHARED_CH-1:0]   pwm01_out,       // Channels 0 and 1.
  output logic [PAM_NPIN-1:0]        gpio_rd_out,     // GPIO read levels.
  output logic [PAM_NFAULT-1:0]      fault_act_out,   // Active faults.
  output logic                       spi_sel_out,     // Slave selected.
  output logic                       spi_sclk_rx_out, // Slave clock in.
  output logic                       spi_mosi_rx_out, // Slave data in.
  output logic                       spi_miso_rx_out, // Master data in.
  output pam_func_t                  func_out [PAM_NPIN] // Current functions.
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  localparam pam_func_t DEF_FUNC = pam_func_t'(FULL_VARIANT ? PAM_FN_PRIMARY
                                                            : PAM_FN_NONE);

  pam_func_t             func_r [PAM_NPIN];  // Selected function per pin.
  logic [PAM_NPIN-1:0]   pin_s;              // Synchronised pin levels.
  logic [PAM_NFAULT-1:0] fault_act;          // Fault pins asserting.
  logic [PAM_NPWM-1:0]   pwm_kill;           // Channels disabled by faults.
  logic [PAM_NPWM-1:0]   pwm_gated;          // Channels after fault gating.
  logic                  slave_sel;          // Slave mode and selected.
  pam_pins_t             pins_nxt;           // Next pin drive and enable.
  pam_pins_t             pins_r;             // Registered pin drive.
  logic [PAM_SHARED_CH-1:0] pwm01_r;         // Registered channels 0, 1.
  logic [PAM_NPIN-1:0]   gpio_rd_r;          // Registered GPIO reads.
  logic [3:0]            spi_rx_r;           // Registered serial inputs.

  // ---------------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------------
  pam_sync3 #(
    .WIDTH (PAM_NPIN)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (pin_in),
    .sync_out   (pin_s)
  );

  // ---------------------------------------------------------------------
  // Function selection
  // ---------------------------------------------------------------------
  // Reset sets the variant default; software then reselects one pin at
  // a time, leaving every other pin untouched.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < PAM_NPIN; i++) begin
        func_r[i] <= DEF_FUNC;
      end
    end else if (sel_load_in && (int'(sel_pin_in) < PAM_NPIN)) begin
      func_r[sel_pin_in] <= sel_func_in;
    end
  end

  // ---------------------------------------------------------------------
  // Fault gating and slave select
  // ---------------------------------------------------------------------
  // A fault pin counts only while it carries its fault function; each
  // asserted fault clears the channels its map names.
  always_comb begin
    pwm_kill = '0;
    for (int k = 0; k < PAM_NFAULT; k++) begin
      fault_act[k] = (func_r[PAM_FAULT_PIN+k] == PAM_FN_PRIMARY)
                     && pin_s[PAM_FAULT_PIN+k];
      if (fault_act[k]) begin
        pwm_kill = pwm_kill | fault_map_in[k];
      end
    end
    pwm_gated = pwm_ch_in & ~pwm_kill;
  end

  // Slave select is active low and only counts in slave mode.
  assign slave_sel = !spi_master_in && !pin_s[PAM_PIN_SS]
                     && (func_r[PAM_PIN_SS] == PAM_FN_ALT);

  // ---------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------
  // Builds drive and enable for every pin from its selected function.
  always_comb begin
    pins_nxt = '0;
    for (int i = 0; i < PAM_NPIN; i++) begin
      if (func_r[i] == PAM_FN_GPIO) begin
        pins_nxt.drive[i] = gpio_data_in[i];
        pins_nxt.oe[i]    = gpio_dir_in[i];
      end
    end
    // Output pins carry PWM channels 2 to 5 as their primary function.
    for (int i = 0; i < PAM_NOUTPIN; i++) begin
      if (func_r[i] == PAM_FN_PRIMARY) begin
        pins_nxt.drive[i] = pwm_gated[i+PAM_SHARED_CH];
        pins_nxt.oe[i]    = 1'b1;
      end
    end
    // Slave data out is driven only while selected, else released.
    if (func_r[PAM_PIN_MISO] == PAM_FN_ALT && !spi_master_in) begin
      pins_nxt.drive[PAM_PIN_MISO] = spi_miso_drv_in;
      pins_nxt.oe[PAM_PIN_MISO]    = slave_sel;
    end
    // Master data out is driven only in master mode.
    if (func_r[PAM_PIN_MOSI] == PAM_FN_ALT && spi_master_in) begin
      pins_nxt.drive[PAM_PIN_MOSI] = spi_mosi_drv_in;
      pins_nxt.oe[PAM_PIN_MOSI]    = 1'b1;
    end
    // Serial clock is an output as master and an input as slave.
    if (func_r[PAM_PIN_SCLK] == PAM_FN_ALT && spi_master_in) begin
      pins_nxt.drive[PAM_PIN_SCLK] = spi_sclk_drv_in;
      pins_nxt.oe[PAM_PIN_SCLK]    = 1'b1;
    end
  end

  // Registers the pin drive; reset releases every pin.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Results toward the core
  // ---------------------------------------------------------------------
  // Registers dedicated PWM channels, GPIO reads and serial inputs.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pwm01_r   <= '0;
      gpio_rd_r <= '0;
      spi_rx_r  <= '0;
    end else begin
      pwm01_r   <= pwm_gated[PAM_SHARED_CH-1:0];
      gpio_rd_r <= pin_s;
      spi_rx_r[0] <= slave_sel;
      spi_rx_r[1] <= !spi_master_in && pin_s[PAM_PIN_SCLK]
                     && (func_r[PAM_PIN_SCLK] == PAM_FN_ALT);
      spi_rx_r[2] <= !spi_master_in && pin_s[PAM_PIN_MOSI]
                     && (func_r[PAM_PIN_MOSI] == PAM_FN_ALT);
      spi_rx_r[3] <= spi_master_in && pin_s[PAM_PIN_MISO]
                     && (func_r[PAM_PIN_MISO] == PAM_FN_ALT);
    end
  end

  assign pins_out        = pins_r;
  assign pwm01_out       = pwm01_r;
  assign gpio_rd_out     = gpio_rd_r;
  assign fault_act_out   = fault_act;
  assign spi_sel_out     = spi_rx_r[0];
  assign spi_sclk_rx_out = spi_rx_r[1];
  assign spi_mosi_rx_out = spi_rx_r[2];
  assign spi_miso_rx_out = spi_rx_r[3];
  assign func_out        = func_r;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // Pins are released on the first edge after reset.
  reset_pins_off_a: assert property (
    $past(rst_in) |-> (pins_out.oe == '0))
    else $error("pin enabled straight after reset");

  // The slave select pin and the last pin hold their variant default after reset.
  reset_default_a: assert property (
    $past(rst_in) |-> (func_r[PAM_PIN_SS] == DEF_FUNC)
                      && (func_r[PAM_NPIN-1] == DEF_FUNC))
    else $error("pin function not at variant default");

  // A GPIO pin follows its direction and data one cycle later.
  gpio_follow_a: assert property (
    (func_r[PAM_FAULT_PIN] == PAM_FN_GPIO) |=>
      (pins_out.oe[PAM_FAULT_PIN] == $past(gpio_dir_in[PAM_FAULT_PIN]))
      && (pins_out.drive[PAM_FAULT_PIN]
          == $past(gpio_data_in[PAM_FAULT_PIN])))
    else $error("GPIO pin does not follow its settings");

  // A shared PWM pin carries its gated channel.
  pwm_pin_pass_a: assert property (
    (func_r[PAM_PIN_SS] == PAM_FN_PRIMARY) |=>
      pins_out.oe[PAM_PIN_SS]
      && (pins_out.drive[PAM_PIN_SS] == $past(pwm_gated[PAM_SHARED_CH])))
    else $error("PWM pin does not carry its channel");

  // A mapped active fault forces the shared channel low.
  fault_kill_a: assert property (
    (fault_act[0] && fault_map_in[0][PAM_SHARED_CH]
     && func_r[PAM_PIN_SS] == PAM_FN_PRIMARY) |=>
      !pins_out.drive[PAM_PIN_SS])
    else $error("fault did not disable PWM output");

  // An unselected slave leaves slave data out released.
  miso_release_a: assert property (
    (func_r[PAM_PIN_MISO] == PAM_FN_ALT && !spi_master_in && !slave_sel)
      |=> !pins_out.oe[PAM_PIN_MISO])
    else $error("unselected slave drives its data line");

  // A selected slave drives the engine's data bit.
  miso_drive_a: assert property (
    (func_r[PAM_PIN_MISO] == PAM_FN_ALT && slave_sel) |=>
      pins_out.oe[PAM_PIN_MISO]
      && (pins_out.drive[PAM_PIN_MISO] == $past(spi_miso_drv_in)))
    else $error("selected slave not driving data");

  // As master, the data line follows the engine.
  mosi_drive_a: assert property (
    (func_r[PAM_PIN_MOSI] == PAM_FN_ALT && spi_master_in) |=>
      pins_out.oe[PAM_PIN_MOSI]
      && (pins_out.drive[PAM_PIN_MOSI] == $past(spi_mosi_drv_in)))
    else $error("master data line not driven");

  // Clock pin direction follows the master flag.
  sclk_dir_a: assert property (
    (func_r[PAM_PIN_SCLK] == PAM_FN_ALT) |=>
      (pins_out.oe[PAM_PIN_SCLK] == $past(spi_master_in)))
    else $error("serial clock pin direction wrong");

  // Selection reaches the engine one cycle after it is seen.
  slave_select_a: assert property (
    slave_sel |=> spi_sel_out)
    else $error("slave select not passed to engine");

endmodule : pam_port_a_mux

// *** pam_pkg.sv ***
// Shared constants and types for the port A pin function multiplexer.
// Assumes a single system clock and a synchronous, active-high reset.
package pam_pkg;

  // ---------------------------------------------------------------------
  // Sizes and pin positions
  // ---------------------------------------------------------------------
  localparam int PAM_NPIN      = 7;  // Pins port_a_io_2 .. port_a_io_8.
  localparam int PAM_NOUTPIN   = 4;  // Pins that can carry PWM channels.
  localparam int PAM_NPWM      = 6;  // PWM channels in the group.
  localparam int PAM_NFAULT    = 3;  // Off-chip fault inputs.
  localparam int PAM_SHARED_CH = 2;  // First channel that uses a shared pin.
  localparam int PAM_FAULT_PIN = 4;  // Pin index of fault_in_0.
  localparam int PAM_PIN_SS    = 0;  // Slave select pin (port_a_io_2).
  localparam int PAM_PIN_MISO  = 1;  // Slave data out pin (port_a_io_3).
  localparam int PAM_PIN_MOSI  = 2;  // Master data out pin (port_a_io_4).
  localparam int PAM_PIN_SCLK  = 3;  // Serial clock pin (port_a_io_5).
  localparam int PAM_SEL_W     = 3;  // Width of a pin index.

  // ---------------------------------------------------------------------
  // Pin function encoding
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAM_FN_PRIMARY = 2'h0,  // PWM output or fault input.
    PAM_FN_ALT     = 2'h1,  // Serial port 1 line (output pins only).
    PAM_FN_GPIO    = 2'h2,  // General-purpose input or output.
    PAM_FN_NONE    = 2'h3   // No usable function; pin released.
  } pam_func_t;

  // Drive value and output enable of the shared pins, travelling together.
  typedef struct packed {
    logic [PAM_NPIN-1:0] drive;  // Level driven while enabled.
    logic [PAM_NPIN-1:0] oe;     // High while the block drives the pin.
  } pam_pins_t;

  // Per fault input, the PWM channels that it disables.
  typedef logic [PAM_NFAULT-1:0][PAM_NPWM-1:0] pam_fault_map_t;

endpackage : pam_pkg

// *** pam_sync3.sv ***
// Three-stage input synchroniser for the shared pins.
// Assumes asynchronous inputs; output changes once stages two and three
// agree, so a single-cycle glitch never reaches the block.
`timescale 1ns/1ns
module pam_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,  // System clock.
  input  wire logic             rst_in,      // Synchronous reset.
  input  wire logic [WIDTH-1:0] async_in,    // Raw pin levels.
  output logic      [WIDTH-1:0] sync_out     // Filtered levels.
);

  // ---------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------
  logic [WIDTH-1:0] st1_r;  // First stage; read by the second only.
  logic [WIDTH-1:0] st2_r;  // Second stage.
  logic [WIDTH-1:0] st3_r;  // Third stage.
  logic [WIDTH-1:0] out_r;  // Accepted level.

  // The chain itself; pins idle high because of their pull-ups.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st1_r <= '1;
      st2_r <= '1;
      st3_r <= '1;
    end else begin
      st1_r <= async_in;
      st2_r <= st1_r;
      st3_r <= st2_r;
    end
  end

  // A bit is accepted only where stages two and three agree.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      out_r <= '1;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (st2_r[i] == st3_r[i]) begin
          out_r[i] <= st3_r[i];
        end
      end
    end
  end

  assign sync_out = out_r;

endmodule : pam_sync3

// *** pam_far_end.sv ***
// Far-side model: serial peer, fault sensors and pin pull-ups.
// Assumes the bench chooses which pins the peer drives and their levels.
`timescale 1ns/1ns
module pam_far_end
  import pam_pkg::*;
(
  input  pam_pins_t                pins_in,  // Block drive and enable.
  input  wire logic [PAM_NPIN-1:0] drv_in,   // Peer levels.
  input  wire logic [PAM_NPIN-1:0] oe_in,    // High where the peer drives.
  output logic      [PAM_NPIN-1:0] lvl_out   // Resolved pin levels.
);
  // ---------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------
  // A released pin floats up, so a stale level never looks driven.
  always_comb begin
    for (int i = 0; i < PAM_NPIN; i++) begin
      if (pins_in.oe[i]) begin
        lvl_out[i] = pins_in.drive[i];
      end else if (oe_in[i]) begin
        lvl_out[i] = drv_in[i];
      end else begin
        lvl_out[i] = 1'b1;
      end
    end
  end
endmodule : pam_far_end

// *** tb.sv ***
// Self-checking bench for the port A pin function multiplexer.
// Assumes the far-side model resolves every shared pin level.
`timescale 1ns/1ns
module tb
  import pam_pkg::*;
;
  // ---------------------------------------------------------------------
  // Stimulus and observation signals
  // ---------------------------------------------------------------------
  typedef struct {int due; string what; logic [64:0] m, e;} pam_note_t;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, sel_load_in = 1'b0;
  logic spi_master_in = 1'b0, miso_d = 1'b0, mosi_d = 1'b0, sclk_d = 1'b0;
  logic [2:0] sel_pin_in = 3'h0;
  pam_func_t sel_func_in = PAM_FN_PRIMARY;
  logic [6:0] dir = 7'h00, dat = 7'h00, xd = 7'h00, xo = 7'h70, lvl, rlvl;
  logic [5:0] pwm = 6'h00, g;
  pam_fault_map_t fmap = '0;
  pam_pins_t pins, rpins;
  logic [1:0] pwm01;
  logic [6:0] grd;
  logic [2:0] fact;
  logic sel, sclk_rx, mosi_rx, miso_rx;
  pam_func_t fo [PAM_NPIN], rfo [PAM_NPIN];
  logic [13:0] fp, rp;
  logic [64:0] obs;
  pam_note_t q [$], nt;
  int cyc = 0, mismatches = 0, n_compared = 0;
  bit m;

  // The clock toggles every half period of 50 ns.
  always #50 clk_sys_in = ~clk_sys_in;

  // ---------------------------------------------------------------------
  // Design, reduced variant and far-side models
  // ---------------------------------------------------------------------
  pam_port_a_mux #(.FULL_VARIANT(1'b1)) dut_u (.clk_sys_in, .rst_in,
    .sel_load_in, .sel_pin_in, .sel_func_in, .gpio_dir_in(dir),
    .gpio_data_in(dat), .pwm_ch_in(pwm), .fault_map_in(fmap),
    .spi_master_in, .spi_miso_drv_in(miso_d), .spi_mosi_drv_in(mosi_d),
    .spi_sclk_drv_in(sclk_d), .pin_in(lvl), .pins_out(pins),
    .pwm01_out(pwm01), .gpio_rd_out(grd), .fault_act_out(fact),
    .spi_sel_out(sel), .spi_sclk_rx_out(sclk_rx),
    .spi_mosi_rx_out(mosi_rx), .spi_miso_rx_out(miso_rx), .func_out(fo));
  pam_port_a_mux #(.FULL_VARIANT(1'b0)) dut_red (.clk_sys_in, .rst_in,
    .sel_load_in, .sel_pin_in, .sel_func_in, .gpio_dir_in(dir),
    .gpio_data_in(dat), .pwm_ch_in(pwm), .fault_map_in(fmap),
    .spi_master_in, .spi_miso_drv_in(miso_d), .spi_mosi_drv_in(mosi_d),
    .spi_sclk_drv_in(sclk_d), .pin_in(rlvl), .pins_out(rpins),
    .pwm01_out(), .gpio_rd_out(), .fault_act_out(), .spi_sel_out(),
    .spi_sclk_rx_out(), .spi_mosi_rx_out(), .spi_miso_rx_out(),
    .func_out(rfo));
  pam_far_end far_u (.pins_in(pins), .drv_in(xd), .oe_in(xo), .lvl_out(lvl));
  pam_far_end far_r (.pins_in(rpins), .drv_in(xd), .oe_in(xo),
    .lvl_out(rlvl));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Packs all observed fields in one fixed order.
  function automatic logic [64:0] pk(logic [13:0] rf, logic [6:0] ro,
    logic [13:0] f, logic [6:0] gr, logic [3:0] s, logic [2:0] fa,
    logic [1:0] p, logic [6:0] d, logic [6:0] o);
    return {rf, ro, f, gr, s, fa, p, d, o};
  endfunction : pk

  task automatic chk(string what, logic [64:0] seen, logic [64:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Files a note due lat edges on and waits until it has been checked.
  task automatic ex(string what, int lat, logic [64:0] mk, logic [64:0] e);
    pam_note_t n0;
    n0.due = cyc + lat;
    n0.what = what;
    n0.m = mk;
    n0.e = e;
    q.push_back(n0);
    repeat (lat) @(negedge clk_sys_in);
  endtask : ex

  // Loads one pin function; the caller lowers the strobe afterwards.
  task automatic ld(logic [2:0] p, pam_func_t f);
    sel_load_in = 1'b1;
    sel_pin_in = p;
    sel_func_in = f;
    @(negedge clk_sys_in);
  endtask : ld

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Watcher: settles past each edge, then checks every note now due.
  always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    #10;
    for (int i = 0; i < PAM_NPIN; i++) begin
      fp[2*i+:2] = fo[i];
      rp[2*i+:2] = rfo[i];
    end
    obs = pk(rp, rpins.oe, fp, grd, {miso_rx, mosi_rx, sclk_rx, sel},
             fact, pwm01, pins.drive, pins.oe);
    while (q.size() > 0 && q[0].due <= cyc) begin
      nt = q.pop_front();
      chk(nt.what, obs & nt.m, nt.e & nt.m);
    end
  end

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (1000) @(posedge clk_sys_in);
    mismatches++;
    results();
  end

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(55812));
    repeat (5) @(negedge clk_sys_in);
    ex("reset", 1, pk('1, '1, '1, '0, '0, '0, '0, '1, '1),
       pk({7{PAM_FN_NONE}}, '0, {7{PAM_FN_PRIMARY}}, '0, '0, '0, '0, '0,
          '0));
    repeat (4) @(negedge clk_sys_in);
    rst_in = 1'b0;
    // Primary functions with random channels, faults and fault maps.
    for (int k = 0; k < 6; k++) begin
      pwm = 6'($urandom());
      fmap = pam_fault_map_t'(18'($urandom()));
      xd = 7'($urandom());
      // First pass forces a mapped fault onto a high shared channel.
      if (k == 0) begin
        pwm[PAM_SHARED_CH] = 1'b1;
        fmap[0][PAM_SHARED_CH] = 1'b1;
        xd[PAM_FAULT_PIN] = 1'b1;
      end
      g = 6'h00;
      for (int j = 0; j < 3; j++) if (xd[4+j]) g = g | fmap[j];
      ex("primary", 7, pk('1, '1, '1, '0, '0, '1, '1, 7'h0F, '1),
         pk({7{PAM_FN_NONE}}, '0, {7{PAM_FN_PRIMARY}}, '0, '0, xd[6:4],
            pwm[1:0] & ~g[1:0], {3'h0, pwm[5:2] & ~g[5:2]}, 7'h0F));
    end
    // Every pin to GPIO back to back, then an ignored out-of-range pin.
    for (int i = 0; i < PAM_NPIN; i++) ld(3'(i), PAM_FN_GPIO);
    ld(3'h7, PAM_FN_NONE);
    sel_load_in = 1'b0;
    for (int k = 0; k < 6; k++) begin
      dir = 7'($urandom());
      dat = 7'($urandom());
      xd = 7'($urandom());
      xo = ~dir;
      ex("gpio", 7, pk('0, '0, '1, '1, '0, '1, '0, dir, '1),
         pk('0, '0, {7{PAM_FN_GPIO}}, (dir & dat) | (~dir & xd), '0, '0,
            '0, dir & dat, dir));
    end
    // Serial lines, alternating slave and master.
    for (int i = 0; i < 4; i++) ld(3'(i), PAM_FN_ALT);
    sel_load_in = 1'b0;
    dir = 7'h00;
    for (int k = 0; k < 10; k++) begin
      m = k[0];
      spi_master_in = m;
      {miso_d, mosi_d, sclk_d} = 3'($urandom());
      xd = 7'($urandom());
      xo = m ? 7'h72 : 7'h7D;
      // Early slave passes cover both a selected and an unselected slave.
      if (k < 4) xd[PAM_PIN_SS] = k[1];
      ex("serial", 7, pk('0, '0, '0, '0, '1, '0, '0,
           m ? 7'h0C : {5'h00, ~xd[0], 1'b0}, 7'h0E),
         pk('0, '0, '0, '0, m ? {xd[1], 3'h0} : {1'b0, xd[2], xd[3], ~xd[0]},
           '0, '0, m ? {3'h0, sclk_d, mosi_d, 2'h0} : {5'h00, miso_d, 1'b0},
           m ? 7'h0C : {5'h00, ~xd[0], 1'b0}));
    end
    repeat (2) @(negedge clk_sys_in);
    if (q.size() > 0) mismatches++;
    results();
  end
endmodule : tb
